//--- hw/pdi_pkg.sv
/*
 * Shared types and constants of the PDCP decapsulation block with
 * confidentiality and integrity: data block layout, override register
 * layout, sequence number sizes and the controller state.
 * Assumes one clock domain and byte-wide frame streams.
 */
package pdi_pkg;

    // Protocol data block words as the job hands them over
    typedef struct packed {
        logic [31:0] word0;                 // Reserved and options byte
        logic [31:0] word1;                 // Hyper frame number, reserved
        logic [31:0] word2;                 // Bearer, direction
        logic [31:0] word3;                 // Renegotiation threshold
    } pdi_pdb_s;

    // Options byte fields in data block word 0
    localparam int unsigned SNS_LSB        = 1;
    localparam logic [1:0]  SNS_SN12       = 2'h0;
    localparam logic [1:0]  SNS_SN7        = 2'h1;
    localparam logic [1:0]  SNS_SN15       = 2'h2;
    localparam logic [3:0]  SN_W_CTRL      = 4'h5;
    localparam logic [3:0]  SN_W_7         = 4'h7;
    localparam logic [3:0]  SN_W_12        = 4'hc;
    localparam logic [3:0]  SN_W_15        = 4'hf;

    // Override register layout and reset value
    localparam int unsigned OVERRIDE_FLAG_FLAG_BIT  = 31;
    localparam logic [31:0] OVERRIDE_FLAG_RESET     = 32'h0000_0000;
    localparam logic [31:0] ALL_ONES       = 32'hffff_ffff;

    // Received integrity check value is four bytes at the tail
    localparam logic [1:0]  ICV_LAST       = 2'h3;
    localparam logic [15:0] ICV_BYTES      = 16'h0004;

    typedef enum logic [3:0] {
        S_IDLE  = 4'b0000,
        S_HDR   = 4'b0001,
        S_CALC  = 4'b0010,
        S_EHDR  = 4'b0011,
        S_PAY   = 4'b0100,
        S_PWAIT = 4'b0101,
        S_MACIN = 4'b0110,
        S_MACO  = 4'b0111,
        S_MWAIT = 4'b1000,
        S_DONE  = 4'b1001
    } pdi_state_e;

    // Whole state of the controller
    typedef struct packed {
        pdi_state_e  st;
        pdi_pdb_s    protocol_data_block;
        logic [31:0] override_flag;
        logic [3:0]  snw;
        logic        hlen2;
        logic        hcnt;
        logic [15:0] hdr;
        logic [15:0] cnt;
        logic [31:0] hyper_frame_number;
        logic [15:0] sn;
        logic [31:0] rx_mac;
        logic [1:0]  mcnt;
        logic        err;
        logic        in_ready;
        logic        c1_load;
        logic        c2_load;
        logic [63:0] iv;
        logic        c1_valid;
        logic [7:0]  c1_data;
        logic        c2_valid;
        logic [7:0]  c2_data;
        logic        c2_last;
        logic        out_valid;
        logic [7:0]  out_data;
        logic        out_last;
        logic        done;
        logic        error;
        logic        warn;
        logic        wb;
        logic [31:0] wb_word1;
    } pdi_reg_s;

endpackage

//--- hw/pdi_decap.sv
/*
 * PDCP decapsulation controller for frames carrying both ciphering and
 * integrity protection. Reads the header, builds the IVs, steers header,
 * payload and received MAC through the class 1 and class 2 engines,
 * checks the MAC and writes out header plus plaintext.
 * Assumes engines, job source and output sink share sys_clk, and that
 * class 2 and the output sink accept a byte on every cycle.
 */
`timescale 1ns/1ps
module pdi_decap (
    input  wire logic              sys_clk,
    input  wire logic              reset,
    input  wire logic              job_start,
    input  wire pdi_pkg::pdi_pdb_s job_pdb,
    input  wire logic [15:0]       job_len,
    input  wire logic              job_ctrl_plane,
    input  wire logic              override_flag_load,
    input  wire logic [31:0]       override_flag_load_data,
    input  wire logic              qi_load,
    input  wire logic [31:0]       qi_status_cmd,
    input  wire logic              in_valid,
    input  wire logic [7:0]        in_data,
    output logic                   in_ready,
    output logic                   c1_iv_load,
    output logic                   c2_iv_load,
    output logic [63:0]            iv,
    output logic                   c1_valid,
    output logic [7:0]             c1_data,
    input  wire logic              c1_pt_valid,
    input  wire logic [7:0]        c1_pt_data,
    output logic                   c2_valid,
    output logic [7:0]             c2_data,
    output logic                   c2_last,
    input  wire logic              c2_mac_valid,
    input  wire logic [31:0]       c2_mac,
    output logic                   out_valid,
    output logic [7:0]             out_data,
    output logic                   out_last,
    output logic                   job_done,
    output logic                   job_error,
    output logic                   job_warning,
    output logic                   wb_desc_valid,
    output logic                   wb_mem_valid,
    output logic [31:0]            wb_word1,
    output logic [31:0]            override_value,
    output logic                   busy
);
    import pdi_pkg::*;

    pdi_reg_s cur;
    pdi_reg_s nxt;

    // Sequence number width from plane and options byte; 0 = reserved
    function automatic logic [3:0] sn_width(input logic ctrl,
                                            input logic [1:0] sel);
        if (ctrl) begin
            return SN_W_CTRL;
        end
        case (sel)
            SNS_SN12: return SN_W_12;
            SNS_SN7:  return SN_W_7;
            SNS_SN15: return SN_W_15;
            default:  return 4'h0;
        endcase
    endfunction

    // Right aligned HYPER_FRAME_NUMBER field mask for a given sequence number width
    function automatic logic [31:0] hfn_mask(input logic [3:0] w);
        return ALL_ONES >> w;
    endfunction

    logic [3:0]  start_w;
    logic [15:0] sn_now;
    logic [31:0] hfn_now;
    logic [31:0] word1_now;

    // Values derived combinationally from the incoming job inputs (start_w) and the latched job
    always_comb begin
        start_w   = sn_width(job_ctrl_plane, job_pdb.word0[SNS_LSB +: 2]);
        // Sequence number is the low snw bits of the header
        sn_now    = cur.hdr & ((16'h0001 << cur.snw) - 16'h0001);
        sn_now    = cur.hlen2 ? sn_now : {8'h00, sn_now[7:0]};
        hfn_now   = (cur.hyper_frame_number + {31'h0, sn_now == 16'h0000})
                    & hfn_mask(cur.snw);
        word1_now = (cur.hyper_frame_number << cur.snw)
                    | (cur.protocol_data_block.word1 & ~(ALL_ONES << cur.snw));
    end

    // Next state; pulses default low each cycle
    always_comb begin
        nxt          = cur;
        nxt.c1_load  = 1'b0;
        nxt.c2_load  = 1'b0;
        nxt.c1_valid = 1'b0;
        nxt.c2_valid = 1'b0;
        nxt.c2_last  = 1'b0;
        nxt.out_valid = 1'b0;
        nxt.out_last = 1'b0;
        nxt.done     = 1'b0;
        nxt.wb       = 1'b0;
        // immediate loads of the override register
        if (qi_load) begin
            nxt.override_flag = qi_status_cmd;
        end else if (override_flag_load) begin
            nxt.override_flag = override_flag_load_data;
        end
        case (cur.st)
            S_IDLE: begin
                if (job_start) begin
                    nxt.protocol_data_block   = job_pdb;
                    nxt.snw   = start_w;
                    nxt.hlen2 = start_w > SN_W_7;
                    nxt.hcnt  = 1'b0;
                    nxt.err   = 1'b0;
                    nxt.warn  = 1'b0;
                    nxt.cnt   = job_len - ICV_BYTES
                                - (start_w > SN_W_7 ? 16'h0002 : 16'h0001);
                    nxt.hyper_frame_number   = cur.override_flag[OVERRIDE_FLAG_FLAG_BIT]
                                ? cur.override_flag & hfn_mask(start_w)
                                : job_pdb.word1 >> start_w;
                    if (start_w == 4'h0) begin
                        nxt.err = 1'b1;
                        nxt.st  = S_DONE;
                    end else begin
                        nxt.in_ready = 1'b1;
                        nxt.st       = S_HDR;
                    end
                end
            end
            S_HDR: begin
                if (in_valid) begin
                    nxt.hdr  = {cur.hdr[7:0], in_data};
                    nxt.hcnt = ~cur.hcnt;
                    if (!cur.hlen2 || cur.hcnt) begin
                        nxt.in_ready = 1'b0;
                        nxt.st       = S_CALC;
                    end
                end
            end
            S_CALC: begin
                // count and IV; wrap bumps HYPER_FRAME_NUMBER
                nxt.sn      = sn_now;
                nxt.hyper_frame_number     = hfn_now;
                nxt.iv      = {(hfn_now << cur.snw) | {16'h0, sn_now},
                               cur.protocol_data_block.word2};
                nxt.c1_load = 1'b1;
                nxt.c2_load = 1'b1;
                nxt.hcnt    = 1'b0;
                nxt.st      = S_EHDR;
            end
            S_EHDR: begin
                // header to class 2 and output, not class 1
                nxt.c2_valid  = 1'b1;
                nxt.out_valid = 1'b1;
                nxt.c2_data   = (cur.hlen2 && !cur.hcnt) ? cur.hdr[15:8]
                                                        : cur.hdr[7:0];
                nxt.out_data  = nxt.c2_data;
                nxt.hcnt      = ~cur.hcnt;
                if (!cur.hlen2 || cur.hcnt) begin
                    nxt.out_last = cur.cnt == 16'h0000;
                    nxt.in_ready = 1'b1;
                    nxt.mcnt     = 2'h0;
                    nxt.st       = (cur.cnt == 16'h0000) ? S_MACIN : S_PAY;
                end
            end
            S_PAY: begin
                if (in_valid) begin
                    nxt.c1_valid = 1'b1;
                    nxt.c1_data  = in_data;
                    nxt.in_ready = 1'b0;
                    nxt.st       = S_PWAIT;
                end
            end
            S_PWAIT: begin
                // plaintext to output and class 2
                if (c1_pt_valid) begin
                    nxt.c2_valid  = 1'b1;
                    nxt.c2_data   = c1_pt_data;
                    nxt.out_valid = 1'b1;
                    nxt.out_data  = c1_pt_data;
                    nxt.out_last  = cur.cnt == 16'h0001;
                    nxt.cnt       = cur.cnt - 16'h0001;
                    nxt.in_ready  = 1'b1;
                    nxt.st = (cur.cnt == 16'h0001) ? S_MACIN : S_PAY;
                end
            end
            S_MACIN: begin
                // received MAC is held back from the output
                if (in_valid) begin
                    nxt.rx_mac = {cur.rx_mac[23:0], in_data};
                    nxt.mcnt   = cur.mcnt + 2'h1;
                    if (cur.mcnt == ICV_LAST) begin
                        nxt.in_ready = 1'b0;
                        nxt.st       = S_MACO;
                    end
                end
            end
            S_MACO: begin
                // received MAC into class 2, high byte first
                nxt.c2_valid = 1'b1;
                nxt.c2_data  = cur.rx_mac[31:24];
                nxt.rx_mac   = {cur.rx_mac[23:0], cur.rx_mac[31:24]};
                nxt.mcnt     = cur.mcnt + 2'h1;
                if (cur.mcnt == ICV_LAST) begin
                    nxt.c2_last = 1'b1;
                    nxt.st      = S_MWAIT;
                end
            end
            S_MWAIT: begin
                // any differing bit is an error
                if (c2_mac_valid) begin
                    nxt.err = c2_mac != cur.rx_mac;
                    nxt.st  = S_DONE;
                end
            end
            S_DONE: begin
                // write back changed word, warn on threshold
                nxt.done     = 1'b1;
                nxt.error    = cur.err;
                nxt.warn     = !cur.err && cur.hyper_frame_number >= cur.protocol_data_block.word3;
                nxt.wb       = !cur.err && word1_now != cur.protocol_data_block.word1;
                nxt.wb_word1 = word1_now;
                nxt.st       = S_IDLE;
            end
            default: nxt.st = S_IDLE;
        endcase
    end

    // State register; synchronous reset
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            cur      <= '0;
            cur.override_flag <= OVERRIDE_FLAG_RESET;
            cur.st   <= S_IDLE;
        end else begin
            cur <= nxt;
        end
    end

    // Outputs straight from state flops
    assign in_ready       = cur.in_ready;
    assign c1_iv_load     = cur.c1_load;
    assign c2_iv_load     = cur.c2_load;
    assign iv             = cur.iv;
    assign c1_valid       = cur.c1_valid;
    assign c1_data        = cur.c1_data;
    assign c2_valid       = cur.c2_valid;
    assign c2_data        = cur.c2_data;
    assign c2_last        = cur.c2_last;
    assign out_valid      = cur.out_valid;
    assign out_data       = cur.out_data;
    assign out_last       = cur.out_last;
    assign job_done       = cur.done;
    assign job_error      = cur.error;
    assign job_warning    = cur.warn;
    assign wb_desc_valid  = cur.wb;
    assign wb_mem_valid   = cur.wb;
    assign wb_word1       = cur.wb_word1;
    assign override_value = cur.override_flag;
    assign busy           = cur.st != S_IDLE;

    // Checks on the controller
    default clocking @(posedge sys_clk); endclocking
    default disable iff (reset);

    property p_ctx_first;
        cur.st == S_CALC |=> c1_iv_load && c2_iv_load && !c2_valid;
    endproperty
    a_ctx_first: assert property (p_ctx_first) else $error("iv late");
    property p_hdr_clear;
        cur.st == S_EHDR |=> c2_valid && out_valid && !c1_valid;
    endproperty
    a_hdr_clear: assert property (p_hdr_clear) else $error("hdr path");
    property p_pt_fwd;
        cur.st == S_PWAIT && c1_pt_valid
            |=> c2_valid && out_valid && c2_data == $past(c1_pt_data);
    endproperty
    a_pt_fwd: assert property (p_pt_fwd) else $error("pt lost");
    property p_mac_last;
        c2_last |-> cur.st == S_MWAIT && !out_valid;
    endproperty
    a_mac_last: assert property (p_mac_last) else $error("mac order");
    property p_mac_err;
        cur.st == S_MWAIT && c2_mac_valid && c2_mac != cur.rx_mac
            |-> ##2 job_done && job_error;
    endproperty
    a_mac_err: assert property (p_mac_err) else $error("no mac error");
    property p_no_icv_out;
        cur.st == S_MACO |-> !out_valid;
    endproperty
    a_no_icv_out: assert property (p_no_icv_out) else $error("icv out");
    property p_rsv_sns;
        cur.st == S_IDLE && job_start && start_w == 4'h0
            |-> ##2 job_done && job_error;
    endproperty
    a_rsv_sns: assert property (p_rsv_sns) else $error("sns 11");
    property p_override_flag_hfn;
        cur.st == S_IDLE && job_start && cur.override_flag[OVERRIDE_FLAG_FLAG_BIT]
            |=> cur.hyper_frame_number == ($past(cur.override_flag) & hfn_mask(cur.snw));
    endproperty
    a_override_flag_hfn: assert property (p_override_flag_hfn) else $error("override_flag hfn");
    property p_pdb_hfn;
        cur.st == S_IDLE && job_start && !cur.override_flag[OVERRIDE_FLAG_FLAG_BIT]
            |=> cur.hyper_frame_number == ($past(job_pdb.word1) >> cur.snw);
    endproperty
    a_pdb_hfn: assert property (p_pdb_hfn) else $error("pdb hfn");
    property p_wrap;
        cur.st == S_CALC && sn_now == 16'h0000
            |=> cur.hyper_frame_number == (($past(cur.hyper_frame_number) + 32'h1) & hfn_mask(cur.snw));
    endproperty
    a_wrap: assert property (p_wrap) else $error("no hfn bump");
    property p_warn;
        cur.st == S_DONE && !cur.err
            |=> job_warning == (cur.hyper_frame_number >= cur.protocol_data_block.word3);
    endproperty
    a_warn: assert property (p_warn) else $error("warning wrong");

    c_good: cover property (job_done && !job_error);
    c_bad: cover property (job_done && job_error);
    c_wb: cover property (wb_desc_valid && job_warning);
endmodule // pdi_decap

//--- verification/pdi_engine_model.sv
/*
 * Stand-in for the class 1 and class 2 engines: xor cipher and an
 * additive 32-bit MAC over every class 2 byte except the last four.
 * Assumes the controller sends bytes on sys_clk with no backpressure.
 */
`timescale 1ns/1ps
module pdi_engine_model (
    input  wire logic        sys_clk,
    input  wire logic        reset,
    input  wire logic        slow,
    input  wire logic        c1_valid,
    input  wire logic [7:0]  c1_data,
    output logic             c1_pt_valid,
    output logic [7:0]       c1_pt_data,
    input  wire logic        c2_valid,
    input  wire logic [7:0]  c2_data,
    input  wire logic        c2_last,
    output logic             c2_mac_valid,
    output logic [31:0]      c2_mac
);
    logic [7:0]  pt;
    logic [31:0] acc, sh, mac;
    int          w1, w2;
    // Idle data toggles so a stale byte is never mistaken for an answer
    always @(posedge sys_clk) begin
        c1_pt_valid  <= 1'b0;
        c2_mac_valid <= 1'b0;
        c1_pt_data   <= ~c1_pt_data;
        c2_mac       <= ~c2_mac;
        if (reset) begin
            w1         <= 0;
            w2         <= 0;
            acc        <= 32'h0000_0000;
            sh         <= 32'h0000_0000;
            c1_pt_data <= 8'h00;
            c2_mac     <= 32'h0000_0000;
        end else begin
            if (c1_valid) begin
                pt <= c1_data ^ 8'h5a;
                w1 <= slow ? 3 : 1;
            end else if (w1 == 1) begin
                c1_pt_valid <= 1'b1;
                c1_pt_data  <= pt;
                w1          <= 0;
            end else if (w1 > 1) begin
                w1 <= w1 - 1;
            end
            if (c2_valid) begin
                sh  <= {sh[23:0], c2_data};
                acc <= acc + {24'h00_0000, sh[31:24]};
                if (c2_last) begin
                    mac <= acc + {24'h00_0000, sh[31:24]};
                    w2  <= slow ? 4 : 1;
                    acc <= 32'h0000_0000;
                    sh  <= 32'h0000_0000;
                end
            end else if (w2 == 1) begin
                c2_mac_valid <= 1'b1;
                c2_mac       <= mac;
                w2           <= 0;
            end else if (w2 > 1) begin
                w2 <= w2 - 1;
            end
        end
    end
endmodule // pdi_engine_model

//--- verification/tb_pdi_decap.sv
/*
 * Self-checking bench for pdi_decap: reset values, a table of jobs,
 * then reserved selector and mid-job reset cases.
 * Assumes pdi_engine_model answers for both engines.
 */
`timescale 1ns/1ps
module tb_pdi_decap;
    import pdi_pkg::*;
    typedef struct packed {
        logic        ctrl;
        logic [1:0]  seq_size_select;
        logic [1:0]  src;      // 1 job ring, 2 queue, 3 both
        logic [31:0] override_flag;
        logic [15:0] hdr;
        logic [3:0]  npay;
        logic [31:0] w1;
        logic [31:0] thr;
        logic        slow;
        logic        exp_err;
        logic        exp_warn;
    } pdi_row_s;
    localparam logic [31:0] BEARER = 32'h0a5c_0000;
    logic        sys_clk, reset, job_start, job_ctrl_plane, override_flag_load;
    logic        qi_load, in_valid, in_ready, c1_iv_load, c2_iv_load;
    logic        c1_valid, c1_pt_valid, c2_valid, c2_last, c2_mac_valid;
    logic        out_valid, out_last, job_done, job_error, job_warning;
    logic        wb_desc_valid, wb_mem_valid, busy, slow;
    logic [7:0]  in_data, c1_data, c1_pt_data, c2_data, out_data;
    logic [15:0] job_len;
    logic [31:0] override_flag_load_data, qi_status_cmd, c2_mac, wb_word1;
    logic [31:0] override_value, wb_seen;
    logic [63:0] iv, iv_seen;
    logic [4:0]  seen;     // done, error, warning, desc wb, mem wb
    pdi_pdb_s    job_pdb;
    logic [7:0]  outq[$];
    int          mismatches, tests_run, cyc, c1_cnt, c1_at_iv, last_at;
    pdi_row_s    rows [8] = '{
        '{1'h1, 2'h0, 2'h0, 32'h0000_0000, 16'h0013, 4'h3, 32'h0000_00a0,
          32'h0000_0064, 1'h0, 1'h0, 1'h0},
        '{1'h0, 2'h1, 2'h0, 32'h0000_0000, 16'h0005, 4'h4, 32'h0000_1980,
          32'h0000_0033, 1'h1, 1'h0, 1'h1},
        '{1'h0, 2'h0, 2'h0, 32'h0000_0000, 16'h8abc, 4'h2, 32'h0001_2000,
          32'h0000_0013, 1'h0, 1'h1, 1'h0},
        '{1'h0, 2'h2, 2'h0, 32'h0000_0000, 16'h8000, 4'h1, 32'hffff_8000,
          32'h0000_0001, 1'h1, 1'h0, 1'h0},
        '{1'h0, 2'h0, 2'h0, 32'h0000_0000, 16'h0000, 4'h2, 32'h0001_2000,
          32'h0000_0013, 1'h0, 1'h1, 1'h0},
        '{1'h0, 2'h1, 2'h1, 32'h8000_002a, 16'h0011, 4'h5, 32'h0000_0380,
          32'h0000_0030, 1'h0, 1'h0, 1'h0},
        '{1'h1, 2'h0, 2'h3, 32'h8000_1234, 16'h0001, 4'h1, 32'h0000_0000,
          32'h0000_1000, 1'h1, 1'h0, 1'h1},
        '{1'h0, 2'h2, 2'h1, 32'h0000_0055, 16'h0102, 4'h3, 32'h0004_8000,
          32'h0000_0009, 1'h0, 1'h0, 1'h1}};

    pdi_decap pdi_decap_inst (.sys_clk, .reset, .job_start, .job_pdb,
        .job_len, .job_ctrl_plane, .override_flag_load, .override_flag_load_data, .qi_load,
        .qi_status_cmd, .in_valid, .in_data, .in_ready, .c1_iv_load,
        .c2_iv_load, .iv, .c1_valid, .c1_data, .c1_pt_valid, .c1_pt_data,
        .c2_valid, .c2_data, .c2_last, .c2_mac_valid, .c2_mac, .out_valid,
        .out_data, .out_last, .job_done, .job_error, .job_warning,
        .wb_desc_valid, .wb_mem_valid, .wb_word1, .override_value, .busy);
    pdi_engine_model pdi_engine_model_inst (.sys_clk, .reset, .slow,
        .c1_valid, .c1_data, .c1_pt_valid, .c1_pt_data, .c2_valid,
        .c2_data, .c2_last, .c2_mac_valid, .c2_mac);

    // Output pulses last one cycle, so they are collected on every edge
    always @(posedge sys_clk) begin
        cyc++;
        if (c1_iv_load === 1'b1) begin
            iv_seen  = iv;
            c1_at_iv = c1_cnt;
        end
        if (c1_valid === 1'b1) c1_cnt++;
        if (out_valid === 1'b1) outq.push_back(out_data);
        if (out_valid === 1'b1 && out_last === 1'b1) last_at = outq.size();
        if (job_done === 1'b1) begin
            seen    = {1'b1, job_error, job_warning, wb_desc_valid,
                       wb_mem_valid};
            wb_seen = wb_word1;
        end
        if (cyc == 20000) begin
            mismatches++;
            end_sim();
        end
    end

    task automatic check(input string what, input logic [63:0] got, exp);
        tests_run++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic end_sim();
        $display("Checks %0d, mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    // Starts a job and clears what the monitor gathered
    task automatic start_job(input pdi_pdb_s p, input logic [15:0] len,
                             input logic ctrl);
        outq.delete();
        c1_cnt   = 0;
        c1_at_iv = -1;
        last_at  = 0;
        seen     = 5'h00;
        job_pdb        <= p;
        job_len        <= len;
        job_ctrl_plane <= ctrl;
        job_start      <= 1'b1;
        @(posedge sys_clk);
        job_start <= 1'b0;
    endtask

    task automatic wait_done();
        for (int n = 0; n < 300 && !seen[4]; n++) @(posedge sys_clk);
        check("job_done", seen[4], 1'b1);
    endtask

    task automatic run_row(input pdi_row_s r);
        logic [3:0]  snw;
        logic [15:0] sn;
        logic [31:0] hyper_frame_number, nhfn, fm, mac;
        logic [7:0]  ib[$];
        logic [7:0]  ex[$];
        logic        exp_wb;
        int          hl, n;
        snw = r.ctrl ? SN_W_CTRL : (r.seq_size_select == SNS_SN7) ? SN_W_7 :
              (r.seq_size_select == SNS_SN15) ? SN_W_15 : SN_W_12;
        hl  = (snw > 4'h7) ? 2 : 1;
        sn  = r.hdr & ((16'h0001 << snw) - 16'h0001);
        fm  = ALL_ONES >> snw;
        hyper_frame_number = r.override_flag[OVERRIDE_FLAG_FLAG_BIT] ? (r.override_flag & fm) : (r.w1 >> snw);
        nhfn = (sn == 16'h0000) ? ((hyper_frame_number + 32'h0000_0001) & fm) : hyper_frame_number;
        exp_wb = ((nhfn << snw) != r.w1) && !r.exp_err;
        if (r.src != 2'h0) begin
            override_flag_load      <= r.src[0];
            qi_load        <= r.src[1];
            override_flag_load_data <= r.src[1] ? ~r.override_flag : r.override_flag;
            qi_status_cmd  <= r.override_flag;
            @(posedge sys_clk);
            override_flag_load <= 1'b0;
            qi_load   <= 1'b0;
            @(posedge sys_clk);
            check("override_value", override_value, r.override_flag);
        end
        if (hl == 2) ib.push_back(r.hdr[15:8]);
        ib.push_back(r.hdr[7:0]);
        ex = ib;
        for (int i = 0; i < r.npay; i++) begin
            ib.push_back(8'hc0 + 8'(i));
            ex.push_back((8'hc0 + 8'(i)) ^ 8'h5a);
        end
        mac = {31'h0000_0000, r.exp_err};
        foreach (ex[i]) mac = mac + {24'h00_0000, ex[i]};
        for (int i = 3; i >= 0; i--) ib.push_back(mac[8*i +: 8]);
        slow <= r.slow;
        start_job('{{29'h0000_0000, r.seq_size_select, 1'b0}, r.w1, BEARER, r.thr},
                  16'(hl + r.npay + 4), r.ctrl);
        foreach (ib[i]) begin
            in_valid <= 1'b1;
            in_data  <= ib[i];
            n = 0;
            do begin
                @(posedge sys_clk);
                n++;
            end while (in_ready !== 1'b1 && n < 100);
        end
        in_valid <= 1'b0;
        wait_done();
        if (sn != 16'h0000)
            check("iv", iv_seen, {(hyper_frame_number << snw) | 32'(sn), BEARER});
        check("data before iv", c1_at_iv, 0);
        check("decrypted bytes", c1_cnt, r.npay);
        check("output length", outq.size(), ex.size());
        foreach (ex[i]) check("output byte", outq[i], ex[i]);
        check("last position", last_at, ex.size());
        check("job_error", seen[3], r.exp_err);
        check("job_warning", seen[2], r.exp_warn);
        if (!r.override_flag[OVERRIDE_FLAG_FLAG_BIT]) begin
            check("wb desc", seen[1], exp_wb);
            check("wb mem", seen[0], exp_wb);
            if (exp_wb) check("wb_word1", wb_seen, nhfn << snw);
        end
    endtask

    initial begin
        sys_clk = 1'b0;
        forever #25 sys_clk = ~sys_clk;
    end

    initial begin
        {reset, job_start, job_ctrl_plane, override_flag_load, qi_load} = 5'h1f;
        {in_valid, slow, job_start, job_ctrl_plane} = 4'h0;
        {override_flag_load, qi_load} = 2'h0;
        {in_data, job_len, override_flag_load_data, qi_status_cmd} = 88'h0;
        job_pdb = '0;
        repeat (10) @(posedge sys_clk);
        reset <= 1'b0;
        @(posedge sys_clk);
        check("override reset", override_value, OVERRIDE_FLAG_RESET);
        check("busy reset", busy, 1'b0);
        foreach (rows[i]) begin
            run_row(rows[i]);
            $display("Test row %0d done", i);
        end
        // Reserved size selector refuses the job without moving data
        start_job('{32'h0000_0006, 32'h0000_0000, BEARER, 32'h0000_0001},
                  16'h0006, 1'b0);
        wait_done();
        check("reserved error", seen[3], 1'b1);
        check("reserved output", outq.size(), 0);
        $display("Test reserved selector done");
        // Reset in mid-job clears the override register as well
        override_flag_load      <= 1'b1;
        override_flag_load_data <= 32'h0000_0001;
        @(posedge sys_clk);
        override_flag_load <= 1'b0;
        run_row(rows[0]);
        start_job('{32'h0000_0000, 32'h0000_0000, BEARER, 32'h0000_0001},
                  16'h0008, 1'b1);
        repeat (3) @(posedge sys_clk);
        reset <= 1'b1;
        repeat (2) @(posedge sys_clk);
        reset <= 1'b0;
        @(posedge sys_clk);
        check("override mid reset", override_value, OVERRIDE_FLAG_RESET);
        check("busy mid reset", busy, 1'b0);
        run_row(rows[0]);
        $display("Test mid-job reset done");
        end_sim();
    end
endmodule // tb_pdi_decap
